// [verilog/mas_sequencer.sv]
// Scan sequencer for a four-channel 16-bit converter with sample memory.
// Assumes converter result pins settle within one conversion time and that
// command and setup inputs come from logic on core_clk.
`timescale 1ns/100ps

module mas_sequencer
	import mas_pkg::*;
#(
	parameter int BUF_DEPTH = BUF_WORDS
)(
	input  wire logic                core_clk,
	input  wire logic                rst,
	input  wire logic                start_cmd,
	input  wire logic                stop_cmd,
	input  wire logic                trig_level_mode,
	input  wire logic [CHAN_W-1:0]   trig_chan,
	input  wire logic [CODE_W-1:0]   trig_thresh,
	input  wire logic                range_current,
	input  wire logic [2:0]          chan_count,
	input  wire logic [31:0]         sample_period,
	output logic                     adc_start,
	output logic [CHAN_W-1:0]        adc_chan,
	output logic                     adc_range,
	input  wire logic [RAW_W-1:0]    adc_raw,
	output logic                     usb_valid,
	output logic [CODE_W-1:0]        usb_data,
	input  wire logic                usb_ready,
	output logic [$clog2(BUF_DEPTH):0] fill_level,
	output logic                     sampling,
	output logic                     samp_err,
	output logic                     overrun
);
	localparam int AW = $clog2(BUF_DEPTH);
	localparam logic [AW:0]   FULL    = (AW+1)'(BUF_DEPTH);
	localparam logic [AW:0]   CNT_INC = (AW+1)'(1);
	localparam logic [AW-1:0] PTR_INC = AW'(1);

	typedef struct packed {
		mas_scan_type       scan;
		logic               armed;
		logic               running;
		logic [31:0]        period_cnt;
		logic [TIME_W-1:0]  time_cnt;
		logic [CHAN_W-1:0]  chan;
		logic               cur_range;
		logic               adc_start;
		logic [RAW_W-1:0]   sync1;
		logic [RAW_W-1:0]   sync2;
		logic               res_valid;
		logic [CODE_W-1:0]  res_data;
		logic               prev_above;
		logic               samp_err;
		logic               overrun;
		logic [AW-1:0]      wr_ptr;
		logic [AW-1:0]      rd_ptr;
		logic [AW:0]        count;
		logic               out_valid;
		logic [CODE_W-1:0]  out_data;
	} mas_core_type;

	mas_core_type        cur;
	mas_core_type        next_cur;
	logic [CODE_W-1:0]   mem [BUF_DEPTH];
	logic [CHAN_W-1:0]   chan_hi;
	logic [TIME_W-1:0]   conv_cyc;
	logic                tick;
	logic                capt;
	logic [CODE_W-1:0]   code;
	logic                above;
	logic                push;
	logic                pop;

	mas_word_if #(.W(CODE_W)) res_if ();
	mas_word_if #(.W(CODE_W)) mem_if ();

	mas_pair_buf #(.W(CODE_W)) u_pair (
		.core_clk (core_clk),
		.rst      (rst),
		.in_port  (res_if),
		.out_port (mem_if)
	);

	assign adc_start  = cur.adc_start;
	assign adc_chan   = cur.chan;
	assign adc_range  = cur.cur_range;
	assign usb_valid  = cur.out_valid;
	assign usb_data   = cur.out_data;
	assign fill_level = cur.count;
	assign sampling   = cur.running;
	assign samp_err   = cur.samp_err;
	assign overrun    = cur.overrun;
	assign res_if.valid = cur.res_valid;
	assign res_if.data  = cur.res_data;

	// Memory is shared: fewer channels simply means more words each
	assign mem_if.ready = (cur.count != FULL);
	assign push = mem_if.valid && mem_if.ready;
	assign pop  = (cur.count != '0) && (!cur.out_valid || usb_ready);

	always_comb begin
		if (chan_count == CNT_ZERO) begin
			chan_hi = CHAN_ZERO;
		end else if (chan_count > CNT_MAX) begin
			chan_hi = CHAN_TOP;
		end else begin
			chan_hi = CHAN_W'(chan_count - CNT_ONE);
		end
	end

	// Range fixed for the whole scan, shared by all channels
	assign conv_cyc = cur.cur_range ? CONV_I_CYC : CONV_V_CYC;
	assign tick     = cur.armed && (cur.period_cnt == '0);
	assign capt     = (cur.scan == ST_CONV) && (cur.time_cnt == '0);
	// Straight binary; front end span sets volts or amps per count
	assign code  = cur.sync2[OVER_BIT] ? CLAMP_CODE : cur.sync2[CODE_W-1:0];
	assign above = (code >= trig_thresh);

	always_comb begin
		next_cur = cur;
		next_cur.adc_start = 1'b0;
		next_cur.res_valid = 1'b0;
		next_cur.sync1 = adc_raw;
		next_cur.sync2 = cur.sync1;
		if (!cur.armed) begin
			next_cur.period_cnt = '0;
		end else if (tick) begin
			next_cur.period_cnt = sample_period - PERIOD_ONE;
		end else begin
			next_cur.period_cnt = cur.period_cnt - PERIOD_ONE;
		end
		unique case (cur.scan)
			ST_IDLE: begin
				if (tick) begin
					next_cur.scan      = ST_CONV;
					next_cur.chan      = CHAN_ZERO;
					next_cur.cur_range = range_current;
					next_cur.time_cnt  = (range_current ? CONV_I_CYC : CONV_V_CYC) - TIME_ONE;
					next_cur.adc_start = 1'b1;
				end
			end
			ST_CONV: begin
				if (capt) begin
					next_cur.res_data  = code;
					next_cur.res_valid = cur.running;
					if (trig_level_mode && (cur.chan == trig_chan)) begin
						next_cur.prev_above = above;
						if (above && !cur.prev_above) begin
							next_cur.running = 1'b1;
						end else if (!above && cur.prev_above) begin
							next_cur.running = 1'b0;
						end
					end
					if (cur.chan == chan_hi) begin
						next_cur.scan     = ST_OVH;
						next_cur.time_cnt = OVH_CYC - TIME_ONE;
					end else begin
						next_cur.chan      = cur.chan + CHAN_ONE;
						next_cur.time_cnt  = conv_cyc - TIME_ONE;
						next_cur.adc_start = 1'b1;
					end
				end else begin
					next_cur.time_cnt = cur.time_cnt - TIME_ONE;
				end
			end
			ST_OVH: begin
				if (cur.time_cnt == '0) begin
					next_cur.scan = ST_IDLE;
				end else begin
					next_cur.time_cnt = cur.time_cnt - TIME_ONE;
				end
			end
			default: begin
				next_cur.scan = ST_IDLE;
			end
		endcase
		if (stop_cmd) begin
			next_cur.armed   = 1'b0;
			next_cur.running = 1'b0;
		end
		if (start_cmd) begin
			next_cur.armed      = 1'b1;
			next_cur.running    = !trig_level_mode;
			next_cur.prev_above = 1'b1;
			next_cur.samp_err   = 1'b0;
			next_cur.overrun    = 1'b0;
		end
		// Event sets come last so they win over a same-cycle clear
		if (tick && (cur.scan != ST_IDLE)) begin
			next_cur.samp_err = 1'b1;
		end
		if (cur.res_valid && !res_if.ready) begin
			next_cur.overrun = 1'b1;
		end
		if (push) begin
			next_cur.wr_ptr = cur.wr_ptr + PTR_INC;
		end
		if (pop) begin
			next_cur.rd_ptr    = cur.rd_ptr + PTR_INC;
			next_cur.out_data  = mem[cur.rd_ptr];
			next_cur.out_valid = 1'b1;
		end else if (usb_ready) begin
			next_cur.out_valid = 1'b0;
		end
		if (push && !pop) begin
			next_cur.count = cur.count + CNT_INC;
		end else if (pop && !push) begin
			next_cur.count = cur.count - CNT_INC;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	// Memory has no reset; only written words are ever read
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[cur.wr_ptr] <= mem_if.data;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	logic [HELP_W-1:0] gap_cnt;
	logic [HELP_W-1:0] scan_cnt;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			gap_cnt  <= '0;
			scan_cnt <= '0;
		end else begin
			gap_cnt  <= cur.adc_start ? HELP_W'(1) : gap_cnt + HELP_W'(1);
			scan_cnt <= (cur.scan == ST_IDLE) ? '0 : scan_cnt + HELP_W'(1);
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_capture;
		capt;
	endsequence

	sequence s_scan_end;
		(cur.scan == ST_OVH) && (cur.time_cnt == '0);
	endsequence

	conv_gap_a: assert property (s_capture |-> gap_cnt == HELP_W'(conv_cyc - TIME_ONE))
		else $error("conversion time wrong");
	chan_step_a: assert property (adc_start && (adc_chan != CHAN_ZERO) |-> $past(capt))
		else $error("channel started without previous result");
	scan_len_a: assert property (s_scan_end |->
		32'(scan_cnt) + 1 == (32'(cur.chan) + 1) * 32'(conv_cyc) + 32'(OVH_CYC))
		else $error("scan length wrong");
	clamp_code_a: assert property (s_capture ##0 cur.sync2[OVER_BIT] |=>
		cur.res_data == CLAMP_CODE)
		else $error("overrange not clamped");
	code_pass_a: assert property (s_capture ##0 !cur.sync2[OVER_BIT] |=>
		cur.res_data == $past(cur.sync2[CODE_W-1:0]))
		else $error("code altered");
	scan_start_a: assert property (adc_start && (adc_chan == CHAN_ZERO) |->
		$past(cur.scan) == ST_IDLE)
		else $error("scan restarted mid-scan");
	samp_err_a: assert property (tick && (cur.scan != ST_IDLE) |=> samp_err)
		else $error("sampling error missed");
	range_hold_a: assert property ((cur.scan != ST_IDLE) && ($past(cur.scan) != ST_IDLE)
		|-> $stable(adc_range))
		else $error("range changed within scan");
	mem_full_a: assert property ((cur.count == FULL) |-> !push ##1 (cur.count <= FULL))
		else $error("memory overfilled");
	sw_start_a: assert property (start_cmd && !trig_level_mode |=> sampling && cur.armed)
		else $error("software start ignored");
endmodule // mas_sequencer

// [verilog/mas_pkg.sv]
// Constants and types for the multichannel converter sequencer.
// Assumes a single 40 MHz core clock; all timing counts derive from it.
package mas_pkg;
	localparam int CLK_MHZ     = 40;
	localparam int CONV_V_NS   = 10_000;
	localparam int CONV_I_NS   = 40_000;
	localparam int OVH_NS      = 20_000;
	localparam int TIME_W      = 11;
	localparam int CHAN_W      = 2;
	localparam int CODE_W      = 16;
	localparam int RAW_W       = CODE_W + 1;
	localparam int MAX_CHAN    = 4;
	localparam int BUF_WORDS   = 262_144;
	localparam int HELP_W      = 16;

	// Least times, rounded up to whole cycles
	localparam logic [TIME_W-1:0] CONV_V_CYC = TIME_W'((CONV_V_NS * CLK_MHZ + 999) / 1000);
	localparam logic [TIME_W-1:0] CONV_I_CYC = TIME_W'((CONV_I_NS * CLK_MHZ + 999) / 1000);
	localparam logic [TIME_W-1:0] OVH_CYC    = TIME_W'((OVH_NS * CLK_MHZ + 999) / 1000);
	localparam logic [TIME_W-1:0] TIME_ONE   = TIME_W'(1);

	localparam logic [CODE_W-1:0] CLAMP_CODE = 16'hFFFE;
	localparam int                OVER_BIT   = CODE_W;
	localparam logic [CHAN_W-1:0] CHAN_ZERO  = 2'h0;
	localparam logic [CHAN_W-1:0] CHAN_ONE   = 2'h1;
	localparam logic [CHAN_W-1:0] CHAN_TOP   = 2'h3;
	localparam logic [2:0]        CNT_ZERO   = 3'h0;
	localparam logic [2:0]        CNT_ONE    = 3'h1;
	localparam logic [2:0]        CNT_MAX    = 3'h4;
	localparam logic [31:0]       PERIOD_ONE = 32'h0000_0001;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01,
		ST_OVH  = 2'b10
	} mas_scan_type;
endpackage

// [verilog/mas_word_if.sv]
// Valid/ready word carrier between the sequencer's own modules.
// Assumes both ends share one clock; no storage inside.
`timescale 1ns/100ps
interface mas_word_if #(parameter int W = 16);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// [verilog/mas_pair_buf.sv]
// Two-entry buffer between the result path and the sample memory.
// Assumes source and sink on core_clk; data leaves from a flop.
`timescale 1ns/100ps
module mas_pair_buf
	import mas_pkg::*;
#(
	parameter int W = 16
)(
	input  wire logic core_clk,
	input  wire logic rst,
	mas_word_if.snk   in_port,
	mas_word_if.src   out_port
);
	typedef struct packed {
		logic [W-1:0] head;
		logic [W-1:0] tail;
		logic [1:0]   fill;
	} mas_pair_type;

	mas_pair_type cur;
	mas_pair_type next_cur;
	logic         push;
	logic         pop;

	assign in_port.ready  = (cur.fill != 2'h2);
	assign out_port.valid = (cur.fill != 2'h0);
	assign out_port.data  = cur.head;
	assign push = in_port.valid && in_port.ready;
	assign pop  = out_port.valid && out_port.ready;

	always_comb begin
		next_cur = cur;
		unique case ({push, pop})
			2'b10: begin
				if (cur.fill == 2'h0) begin
					next_cur.head = in_port.data;
				end else begin
					next_cur.tail = in_port.data;
				end
				next_cur.fill = cur.fill + 2'h1;
			end
			2'b01: begin
				next_cur.head = cur.tail;
				next_cur.fill = cur.fill - 2'h1;
			end
			2'b11: begin
				// Fill stays; the word behind moves up
				if (cur.fill == 2'h1) begin
					next_cur.head = in_port.data;
				end else begin
					next_cur.head = cur.tail;
					next_cur.tail = in_port.data;
				end
			end
			2'b00: begin
				next_cur = cur;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end
endmodule // mas_pair_buf

// [tb/mas_host_model.sv]
// Host end of the result stream: takes words and can stall on command.
// Assumes words are offered on core_clk with a valid/ready handshake.
`timescale 1ns/100ps
module mas_host_model
	import mas_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic              stall,
	input  wire logic              usb_valid,
	input  wire logic [CODE_W-1:0] usb_data,
	output logic                   usb_ready
);
	logic [CODE_W-1:0] words[$];

	initial usb_ready = 1'b0;
	// Ready moves after the falling edge, clear of the sampling edge
	always @(negedge core_clk) begin
		usb_ready <= !stall && !rst;
	end
	always @(posedge core_clk) begin
		if (usb_valid === 1'b1 && usb_ready === 1'b1) begin
			words.push_back(usb_data);
		end
	end
endmodule // mas_host_model

// [tb/mas_sequencer_bench.sv]
// Self-checking bench for the scan sequencer, host model on the stream.
// Assumes a 16-word sample memory so that overrun is reached quickly.
`timescale 1ns/100ps
module mas_sequencer_bench;
	import mas_pkg::*;
	localparam int DEPTH = 16;
	logic                   core_clk = 1'b0;
	logic                   rst = 1'b1;
	logic                   start_cmd = 1'b0;
	logic                   stop_cmd = 1'b0;
	logic                   trig_level_mode = 1'b0;
	logic [CHAN_W-1:0]      trig_chan = 2'h1;
	logic [CODE_W-1:0]      trig_thresh = 16'h4000;
	logic                   range_current = 1'b0;
	logic [2:0]             chan_count = 3'h4;
	logic [31:0]            sample_period = 32'h0000_1388;
	logic [RAW_W-1:0]       adc_raw = 17'h0_0000;
	logic                   stall = 1'b0;
	logic                   adc_start, adc_range, usb_valid, usb_ready;
	logic                   sampling, samp_err, overrun;
	logic [CHAN_W-1:0]      adc_chan;
	logic [CODE_W-1:0]      usb_data;
	logic [4:0]             fill_level;
	logic [RAW_W-1:0]       raw_tab[4] = '{17'h0_8000, 17'h0_0000, 17'h0_FFFF, 17'h1_1234};
	logic [CODE_W-1:0]      exp_code[4] = '{16'h8000, 16'h0000, 16'hFFFF, 16'hFFFE};
	int                     failures = 0;
	int                     tests_run = 0;
	int                     cyc = 0;
	int                     st_t[$];
	logic [CHAN_W-1:0]      st_c[$];
	logic                   st_r[$];

	always #12.5 core_clk = ~core_clk;

	mas_sequencer #(.BUF_DEPTH(DEPTH)) i_mas_sequencer (.core_clk(core_clk), .rst(rst),
		.start_cmd(start_cmd), .stop_cmd(stop_cmd), .trig_level_mode(trig_level_mode),
		.trig_chan(trig_chan), .trig_thresh(trig_thresh), .range_current(range_current),
		.chan_count(chan_count), .sample_period(sample_period), .adc_start(adc_start),
		.adc_chan(adc_chan), .adc_range(adc_range), .adc_raw(adc_raw),
		.usb_valid(usb_valid), .usb_data(usb_data), .usb_ready(usb_ready),
		.fill_level(fill_level), .sampling(sampling), .samp_err(samp_err),
		.overrun(overrun));
	mas_host_model i_mas_host_model (.core_clk(core_clk), .rst(rst), .stall(stall),
		.usb_valid(usb_valid), .usb_data(usb_data), .usb_ready(usb_ready));

	////////////////////////////////////////////////////////////////////////////
	// Converter pins follow the selected channel; overrange lives in bit 16
	always @(negedge core_clk) begin
		adc_raw <= raw_tab[adc_chan];
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (adc_start === 1'b1) begin
			st_t.push_back(cyc);
			st_c.push_back(adc_chan);
			st_r.push_back(adc_range);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic pulse(input logic stop);
		if (stop) stop_cmd = 1'b1;
		else start_cmd = 1'b1;
		tick(1);
		stop_cmd = 1'b0;
		start_cmd = 1'b0;
	endtask
	task automatic fresh;
		st_t.delete();
		st_c.delete();
		st_r.delete();
		i_mas_host_model.words.delete();
	endtask
	// Stop, then let any scan in flight and its overhead run out
	// Wait sized from the live setup keeps the run short
	task automatic halt;
		int span;
		span = int'(chan_count) * int'(range_current ? CONV_I_CYC : CONV_V_CYC);
		pulse(1'b1);
		tick(span + int'(OVH_CYC) + 4);
		chk("sampling after stop", sampling, 1'b0);
	endtask
	task automatic wait_words(input int n);
		int k;
		for (k = 0; k < 20000 && i_mas_host_model.words.size() < n; k++) tick(1);
		chk("word count", i_mas_host_model.words.size() >= n, 1'b1);
	endtask
	task automatic check_scan(input int n, input int gap, input logic rng);
		int i;
		chk("start count", st_t.size(), n);
		for (i = 0; i < n && i < st_t.size(); i++) begin
			chk("channel order", st_c[i], i[1:0]);
			chk("range in use", st_r[i], rng);
			if (i > 0) chk("conversion gap", st_t[i] - st_t[i-1], gap);
			if (i < i_mas_host_model.words.size())
				chk("stored code", i_mas_host_model.words[i], exp_code[i]);
		end
	endtask
	task automatic finish_test;
		if (failures == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_volt_scan;
		range_current = 1'b0;
		chan_count = 3'h4;
		sample_period = 32'h0000_1388;
		fresh();
		pulse(1'b0);
		wait_words(4);
		halt();
		check_scan(4, 400, 1'b0);
	endtask
	task automatic t_curr_scan;
		range_current = 1'b1;
		chan_count = 3'h2;
		sample_period = 32'h0000_2710;
		fresh();
		pulse(1'b0);
		wait_words(2);
		halt();
		check_scan(2, 1600, 1'b1);
	endtask
	// One channel in voltage takes 1200 cycles per scan
	task automatic t_samp_err;
		range_current = 1'b0;
		chan_count = 3'h1;
		// Period well above the 1200-cycle scan; second tick lands while idle
		sample_period = 32'h0000_1F40;
		pulse(1'b0);
		tick(8100);
		chk("sampling running", sampling, 1'b1);
		chk("error with slack", samp_err, 1'b0);
		halt();
		sample_period = 32'h0000_047E;
		pulse(1'b0);
		tick(6000);
		chk("error when short", samp_err, 1'b1);
		halt();
		pulse(1'b0);
		tick(2);
		chk("error cleared", samp_err, 1'b0);
		halt();
	endtask
	task automatic t_overrun;
		int k;
		int i;
		chan_count = 3'h4;
		sample_period = 32'h0000_09C4;
		stall = 1'b1;
		fresh();
		pulse(1'b0);
		for (k = 0; k < 30000 && overrun !== 1'b1; k++) tick(1);
		chk("overrun", overrun, 1'b1);
		chk("memory full", fill_level, DEPTH);
		halt();
		stall = 1'b0;
		for (k = 0; k < 400 && (fill_level !== 5'h0 || usb_valid !== 1'b0); k++) tick(1);
		chk("memory drained", fill_level, 5'h0);
		chk("drained count", i_mas_host_model.words.size() >= DEPTH, 1'b1);
		for (i = 0; i < i_mas_host_model.words.size(); i++)
			chk("drained code", i_mas_host_model.words[i], exp_code[i % 4]);
	endtask
	task automatic t_level;
		int k;
		trig_level_mode = 1'b1;
		raw_tab[1] = 17'h0_0000;
		pulse(1'b0);
		tick(6000);
		chk("held below level", sampling, 1'b0);
		raw_tab[1] = 17'h0_F000;
		for (k = 0; k < 20000 && sampling !== 1'b1; k++) tick(1);
		chk("rising start", sampling, 1'b1);
		raw_tab[1] = 17'h0_0000;
		for (k = 0; k < 20000 && sampling !== 1'b0; k++) tick(1);
		chk("falling stop", sampling, 1'b0);
		halt();
		trig_level_mode = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		tick(20);
		rst = 1'b0;
		tick(1);
		t_volt_scan();
		t_curr_scan();
		t_samp_err();
		t_overrun();
		t_level();
		finish_test();
	end
	// Sequence needs about 60k cycles; margin covers slow level crossings
	initial begin
		repeat (90000) @(posedge core_clk);
		failures++;
		finish_test();
	end
endmodule // mas_sequencer_bench
